// [hw/apdu_frame_checker_regs.vh]
`ifndef APDU_FRAME_CHECKER_REGS_VH
`define APDU_FRAME_CHECKER_REGS_VH
`define CLA_INVALID 8'hFF
`define INS_NIBBLE_A 4'h6
`define INS_NIBBLE_B 4'h9
`define SFI_LOW 5'h00
`define SFI_HIGH 5'h1F
`define CASE_1 2'h0
`define CASE_2 2'h1
`define CASE_3 2'h2
`define CASE_4 2'h3
`define ERR_CLA 0
`define ERR_INS 1
`define ERR_LC 2
`define ERR_LEN 3
`define ERR_SFI 4
`define ERR_RESP 5
`define ERR_W 6
`define LE_ZERO_MAX 9'h100
`endif

// [hw/apdu_frame_checker.v]
`timescale 1ns/100ps
// What this block does
// - classify command into case one to four
// - secure messaging lifts case 1/2 to 3/4
// - header is class, instruction, param1, param2
// - class byte FF is invalid
// - instruction needs lsb zero, nibble not 6/9
// - command length must be 1 to 255
// - count data bytes against command length
// - expected length zero means 256 bytes
// - bytes after header follow the case layout
// - response is data then two status bytes
// - response body must not exceed expected length
// - short file identifier must be 1 to 30
`include "apdu_frame_checker_regs.vh"
module apdu_frame_checker (
  input wire sys_clk,
  input wire resetn,
  input wire cmd_start,
  input wire [1:0] cmd_case,
  input wire secure_messaging,
  input wire sfi_check,
  input wire cmd_valid,
  input wire [7:0] cmd_data,
  input wire cmd_last,
  output wire cmd_ready,
  output wire out_valid,
  output wire [7:0] out_data,
  output wire out_last,
  input wire out_ready,
  input wire rsp_valid,
  input wire [7:0] rsp_data,
  input wire rsp_last,
  output reg [1:0] eff_case,
  output reg cmd_done,
  output reg [`ERR_W-1:0] error_flags,
  output reg [8:0] rsp_limit,
  output reg [7:0] status_1,
  output reg [7:0] status_2,
  output reg rsp_done
);
  localparam S_IDLE = 7'b0000001;
  localparam S_HDR = 7'b0000010;
  localparam S_LC = 7'b0000100;
  localparam S_DATA = 7'b0001000;
  localparam S_LE = 7'b0010000;
  localparam S_END = 7'b0100000;
  localparam S_DROP = 7'b1000000;
  // the response-length flag outlives a command, every other flag is per command
  localparam [`ERR_W-1:0] RESP_MASK = {{(`ERR_W-1){1'b0}}, 1'b1} << `ERR_RESP;

  reg [6:0] state;
  reg [1:0] hdr_idx;
  reg [7:0] data_left;
  reg [7:0] ins_byte;
  reg [`ERR_W-1:0] err_acc;
  // header bytes are held until the header checks pass, so a bad header is never forwarded
  reg [7:0] hdr_buf [0:3];
  reg [2:0] flush_idx;
  reg flushing;
  // two-entry skid buffer toward the transport side
  reg [7:0] buf_data [0:1];
  reg [1:0] buf_last;
  reg [1:0] count;
  reg rd_ptr;
  reg wr_ptr;
  reg [9:0] rsp_count;
  reg [7:0] rsp_hold0;
  reg [1:0] rsp_seen;
  integer i;

  function has_cmd_data;
    input [1:0] c;
    has_cmd_data = (c == `CASE_3) || (c == `CASE_4);
  endfunction

  function has_le;
    input [1:0] c;
    has_le = (c == `CASE_2) || (c == `CASE_4);
  endfunction

  function [1:0] lift_case;
    input [1:0] c;
    input sm;
    begin
      lift_case = c;
      if (sm && c == `CASE_1)
        lift_case = `CASE_3;
      else if (sm && c == `CASE_2)
        lift_case = `CASE_4;
    end
  endfunction

  // an identifier of all zeros or all ones is reserved, so both ends are rejected
  function sfi_bad;
    input [4:0] v;
    sfi_bad = (v == `SFI_LOW) || (v == `SFI_HIGH);
  endfunction

  // odd codes and the 6x/9x rows are reserved instruction values
  function ins_invalid;
    input [7:0] b;
    ins_invalid = b[0] || b[7:4] == `INS_NIBBLE_A || b[7:4] == `INS_NIBBLE_B;
  endfunction

  // body layout that follows a clean header
  function [6:0] after_hdr;
    input [1:0] c;
    begin
      if (has_cmd_data(c))
        after_hdr = S_LC;
      else if (has_le(c))
        after_hdr = S_LE;
      else
        after_hdr = S_END;
    end
  endfunction

  wire buf_full = (count == 2'h2);
  wire buf_push;
  wire [7:0] push_data;
  wire push_last;
  assign out_valid = (count != 2'h0);
  assign out_data = buf_data[rd_ptr];
  assign out_last = buf_last[rd_ptr];
  wire buf_pop = out_valid && out_ready;

  wire in_body = (state == S_LC) || (state == S_DATA) || (state == S_LE);
  // header bytes are never stalled; body bytes wait while the header flush runs or the buffer is full
  assign cmd_ready = (state == S_HDR) || (state == S_DROP) || (in_body && !flushing && !buf_full);
  wire take = cmd_valid && cmd_ready;

  assign buf_push = (flushing && !buf_full) || (take && in_body);
  assign push_data = flushing ? hdr_buf[flush_idx[1:0]] : cmd_data;
  // a case one command ends with its fourth header byte, so the flush marks it last
  assign push_last = flushing ? (flush_idx == 3'h3 && state == S_END) :
                     (cmd_last || (state == S_DATA && data_left == 8'h01 && !has_le(eff_case)) || state == S_LE);

  wire ins_bad = ins_invalid(ins_byte);
  wire [4:0] sfi_val = cmd_data[7:3];

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      buf_last <= 2'h0;
      buf_data[0] <= 8'h00;
      buf_data[1] <= 8'h00;
    end else begin
      if (buf_push) begin
        buf_data[wr_ptr] <= push_data;
        buf_last[wr_ptr] <= push_last;
        wr_ptr <= ~wr_ptr;
      end
      if (buf_pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      hdr_idx <= 2'h0;
      data_left <= 8'h00;
      ins_byte <= 8'h00;
      err_acc <= {`ERR_W{1'b0}};
      error_flags <= {`ERR_W{1'b0}};
      eff_case <= `CASE_1;
      cmd_done <= 1'b0;
      rsp_limit <= 9'h000;
      flush_idx <= 3'h0;
      flushing <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        hdr_buf[i] <= 8'h00;
    end else begin
      cmd_done <= 1'b0;
      if (flushing && !buf_full) begin
        flush_idx <= flush_idx + 3'h1;
        if (flush_idx == 3'h3)
          flushing <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (cmd_start) begin
            eff_case <= lift_case(cmd_case, secure_messaging);
            hdr_idx <= 2'h0;
            err_acc <= {`ERR_W{1'b0}};
            error_flags <= error_flags & RESP_MASK;
            state <= S_HDR;
          end
        end
        S_HDR: if (take) begin
          hdr_buf[hdr_idx] <= cmd_data;
          hdr_idx <= hdr_idx + 2'h1;
          if (hdr_idx == 2'h0 && cmd_data == `CLA_INVALID)
            err_acc[`ERR_CLA] <= 1'b1;
          if (hdr_idx == 2'h1)
            ins_byte <= cmd_data;
          if (hdr_idx == 2'h3 && sfi_check && sfi_bad(sfi_val))
            err_acc[`ERR_SFI] <= 1'b1;
          if (cmd_last && hdr_idx != 2'h3) begin
            // shorter than its header: dropped before anything is forwarded
            err_acc[`ERR_LEN] <= 1'b1;
            state <= S_END;
          end else if (hdr_idx == 2'h3) begin
            if (err_acc[`ERR_CLA] || ins_bad || (sfi_check && sfi_bad(sfi_val))) begin
              // a bad header that is also the final byte has nothing left to swallow
              state <= cmd_last ? S_END : S_DROP;
              err_acc[`ERR_INS] <= ins_bad;
            end else if (cmd_last && after_hdr(eff_case) != S_END) begin
              // cut right after the header: the body is missing, so nothing is sent on
              err_acc[`ERR_LEN] <= 1'b1;
              state <= S_END;
            end else begin
              flushing <= 1'b1;
              flush_idx <= 3'h0;
              rsp_limit <= 9'h000;
              state <= after_hdr(eff_case);
            end
          end
        end
        S_LC: if (take) begin
          data_left <= cmd_data;
          if (cmd_data == 8'h00 || cmd_last) begin
            err_acc[`ERR_LC] <= 1'b1;
            state <= cmd_last ? S_END : S_DROP;
          end else
            state <= S_DATA;
        end
        S_DATA: if (take) begin
          data_left <= data_left - 8'h01;
          if (cmd_last && (data_left != 8'h01 || has_le(eff_case))) begin
            err_acc[`ERR_LEN] <= 1'b1;
            state <= S_END;
          end else if (data_left == 8'h01)
            state <= has_le(eff_case) ? S_LE : S_END;
        end
        S_LE: if (take) begin
          rsp_limit <= (cmd_data == 8'h00) ? `LE_ZERO_MAX : {1'b0, cmd_data};
          if (!cmd_last)
            err_acc[`ERR_LEN] <= 1'b1;
          state <= cmd_last ? S_END : S_DROP;
        end
        S_DROP: if (take && cmd_last)
          state <= S_END;
        S_END: if (!flushing) begin
          error_flags <= err_acc | (error_flags & RESP_MASK);
          cmd_done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
      if (cmd_start && state == S_IDLE)
        error_flags[`ERR_RESP] <= 1'b0;
      // placed after the clear so that a late response still reports its overrun
      if (rsp_done && rsp_count > {1'b0, rsp_limit})
        error_flags[`ERR_RESP] <= 1'b1;
    end
  end

  // response: the last two bytes are the trailer, everything before is body
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_count <= 10'h000;
      rsp_hold0 <= 8'h00;
      rsp_seen <= 2'h0;
      status_1 <= 8'h00;
      status_2 <= 8'h00;
      rsp_done <= 1'b0;
    end else begin
      rsp_done <= 1'b0;
      if (rsp_done) begin
        rsp_count <= 10'h000;
        rsp_seen <= 2'h0;
      end
      if (rsp_valid) begin
        rsp_hold0 <= rsp_data;
        if (rsp_done) begin
          // back-to-back frames: this byte already opens the next response
          rsp_seen <= 2'h1;
          rsp_count <= 10'h000;
        end else if (rsp_seen != 2'h2)
          rsp_seen <= rsp_seen + 2'h1;
        else if (rsp_count != 10'h3FF)
          // saturate so an overlong body cannot wrap back under the limit
          rsp_count <= rsp_count + 10'h001;
        if (rsp_last) begin
          status_1 <= rsp_hold0;
          status_2 <= rsp_data;
          rsp_done <= 1'b1;
        end
      end
    end
  end
endmodule

// [testbench/apdu_frame_checker_asserts.sv]
`timescale 1ns/100ps
`include "apdu_frame_checker_regs.vh"
module apdu_frame_checker_asserts (
  input wire sys_clk,
  input wire resetn,
  input wire cmd_start,
  input wire [1:0] cmd_case,
  input wire secure_messaging,
  input wire sfi_check,
  input wire cmd_valid,
  input wire [7:0] cmd_data,
  input wire cmd_ready,
  input wire out_valid,
  input wire [7:0] out_data,
  input wire out_ready,
  input wire rsp_valid,
  input wire [7:0] rsp_data,
  input wire rsp_last,
  input wire [1:0] eff_case,
  input wire cmd_done,
  input wire [`ERR_W-1:0] error_flags,
  input wire rsp_done,
  input wire [7:0] status_2
);
  reg [2:0] idx;
  wire take = cmd_valid && cmd_ready;
  // byte position inside the command, saturates past the header
  always @(posedge sys_clk or negedge resetn)
    if (!resetn) idx <= 3'h0;
    else if (cmd_start) idx <= 3'h0;
    else if (take && idx != 3'h7) idx <= idx + 3'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sm_lift_a: assert property (cmd_start && secure_messaging && !cmd_case[1]
    |-> ##[1:8] eff_case == {1'b1, cmd_case[0]}) else $error("lifted case wrong");
  cla_bad_a: assert property (take && idx == 3'h0 && cmd_data == `CLA_INVALID
    |-> ##[1:300] cmd_done && error_flags[`ERR_CLA]) else $error("class not flagged");
  ins_bad_a: assert property (take && idx == 3'h1 && (cmd_data[0] || cmd_data[7:4] == `INS_NIBBLE_A
    || cmd_data[7:4] == `INS_NIBBLE_B) |-> ##[1:300] cmd_done && error_flags[`ERR_INS]) else $error("ins not flagged");
  sfi_bad_a: assert property (take && idx == 3'h3 && sfi_check && (cmd_data[7:3] == `SFI_LOW
    || cmd_data[7:3] == `SFI_HIGH) |-> ##[1:300] cmd_done && error_flags[`ERR_SFI]) else $error("sfi not flagged");
  done_pulse_a: assert property (cmd_done |=> !cmd_done) else $error("done too long");
  rsp_done_a: assert property (rsp_valid && rsp_last |=> rsp_done) else $error("no rsp done");
  trailer_a: assert property (rsp_valid && rsp_last |=> status_2 == $past(rsp_data)) else $error("bad trailer");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output dropped");
  cover property (cmd_done && eff_case == `CASE_4);
  cover property (rsp_done && error_flags[`ERR_RESP]);
  cover property (out_valid && !out_ready);
endmodule
bind apdu_frame_checker apdu_frame_checker_asserts apdu_frame_checker_asserts_inst (.*);

// [testbench/card_link_model.sv]
`timescale 1ns/100ps
module card_link_model (
  input wire sys_clk,
  input wire out_valid,
  input wire [7:0] out_data,
  input wire out_last,
  output reg out_ready,
  output reg rsp_valid,
  output reg [7:0] rsp_data,
  output reg rsp_last
);
  reg [7:0] got [$];
  reg slow = 1'b0;
  reg got_last = 1'b0;
  initial begin
    out_ready = 1'b0;
    rsp_valid = 1'b0;
    rsp_data = 8'h00;
    rsp_last = 1'b0;
  end
  // slow mode stalls every other cycle so the buffer fills
  always @(negedge sys_clk) out_ready <= slow ? ~out_ready : 1'b1;
  always @(posedge sys_clk) begin
    if (out_valid && out_ready) begin
      got.push_back(out_data);
      got_last <= out_last;
    end
  end
  task send_rsp(input int n, input [7:0] s1, input [7:0] s2);
    for (int i = 0; i < n + 2; i++) begin
      @(negedge sys_clk);
      rsp_valid = 1'b1;
      rsp_data = (i == n) ? s1 : (i == n + 1) ? s2 : 8'hA0 + i[7:0];
      rsp_last = (i == n + 1);
    end
    @(negedge sys_clk);
    rsp_valid = 1'b0;
    rsp_last = 1'b0;
    rsp_data = ~rsp_data;
  endtask
endmodule

// [testbench/apdu_frame_checker_bench.sv]
`timescale 1ns/100ps
`include "apdu_frame_checker_regs.vh"
module apdu_frame_checker_bench;
  reg sys_clk, resetn, cmd_start, secure_messaging, sfi_check, cmd_valid, cmd_last;
  reg [1:0] cmd_case;
  reg [7:0] cmd_data;
  wire cmd_ready, out_valid, out_last, out_ready, rsp_valid, rsp_last, cmd_done, rsp_done;
  wire [7:0] out_data, rsp_data, status_1, status_2;
  wire [1:0] eff_case;
  wire [`ERR_W-1:0] error_flags;
  wire [8:0] rsp_limit;
  reg [7:0] q [$];
  int num_errors = 0;
  int n_checks = 0;
  apdu_frame_checker apdu_frame_checker_inst (.sys_clk(sys_clk), .resetn(resetn), .cmd_start(cmd_start),
    .cmd_case(cmd_case), .secure_messaging(secure_messaging), .sfi_check(sfi_check), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_ready(cmd_ready), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_ready(out_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .eff_case(eff_case), .cmd_done(cmd_done), .error_flags(error_flags), .rsp_limit(rsp_limit),
    .status_1(status_1), .status_2(status_2), .rsp_done(rsp_done));
  card_link_model card_link_model_inst (.sys_clk(sys_clk), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last),
    .out_ready(out_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cmd(input [1:0] cs, input sm, input sf, input [5:0] ee, input int fwd);
    int k;
    card_link_model_inst.got.delete();
    @(negedge sys_clk);
    {cmd_case, secure_messaging, sfi_check, cmd_start} = {cs, sm, sf, 1'b1};
    @(negedge sys_clk);
    cmd_start = 1'b0;
    foreach (q[i]) begin
      {cmd_valid, cmd_data, cmd_last} = {1'b1, q[i], i == q.size() - 1};
      for (k = 0; cmd_ready !== 1'b1 && k < 50; k++) @(negedge sys_clk);
      @(negedge sys_clk);
    end
    {cmd_valid, cmd_last} = 2'b00;
    for (k = 0; cmd_done !== 1'b1 && k < 300; k++) @(negedge sys_clk);
    check("done", cmd_done, 1'b1);
    check("flags", error_flags, ee);
    for (k = 0; card_link_model_inst.got.size() != fwd && k < 40; k++) @(negedge sys_clk);
    if (fwd >= 0) check("fwd", card_link_model_inst.got.size(), fwd);
    if (fwd > 0) check("last", card_link_model_inst.got_last, 1'b1);
  endtask
  task t_cases;
    reg [1:0] e;
    for (int s = 0; s < 2; s++) for (int c = 0; c < 4; c++) begin
      e = (s == 1 && c < 2) ? c[1:0] + 2'h2 : c[1:0];
      q = {8'h00, 8'hB2, 8'h01, 8'h0C};
      if (e[1]) q = {q, 8'h02, 8'h11, 8'h22};
      if (e[0]) q.push_back(8'h00);
      card_link_model_inst.slow = s[0];
      cmd(c[1:0], s[0], 1'b0, 6'h00, q.size());
      check("case", eff_case, e);
      check("limit", rsp_limit, e[0] ? `LE_ZERO_MAX : 9'h000);
      check("order", card_link_model_inst.got[1], 8'hB2);
    end
  endtask
  task t_header;
    reg [31:0] hv [8] = '{32'hFFB20C01, 32'h00B30C02, 32'h00640C02, 32'h00920C02,
      32'h00B20490, 32'h00B2FC90, 32'h00B2F480, 32'h00B20C80};
    foreach (hv[i]) begin
      q = {hv[i][31:24], hv[i][23:16], 8'h01, hv[i][15:8]};
      cmd(`CASE_1, 1'b0, hv[i][7], hv[i][5:0], (hv[i][5:0] != 0) ? 0 : 4);
    end
  endtask
  task t_length;
    q = {8'h00, 8'hB2, 8'h01, 8'h0C, 8'h00};
    cmd(`CASE_3, 1'b0, 1'b0, 6'h04, -1);
    q = {8'h00, 8'hB2, 8'h01, 8'h0C, 8'h02, 8'h33};
    cmd(`CASE_3, 1'b0, 1'b0, 6'h08, -1);
    q = {8'h00, 8'hB2, 8'h01, 8'h0C, 8'hFF};
    repeat (255) q.push_back(8'h5A);
    cmd(`CASE_3, 1'b0, 1'b0, 6'h00, 260);
    q = {8'h00, 8'hB2, 8'h01, 8'h0C};
    cmd(`CASE_2, 1'b0, 1'b0, 6'h08, 0);
    q = {8'h00, 8'hB2};
    cmd(`CASE_1, 1'b0, 1'b0, 6'h08, 0);
  endtask
  task t_resp;
    q = {8'h00, 8'hB2, 8'h01, 8'h0C, 8'h05};
    cmd(`CASE_2, 1'b0, 1'b0, 6'h00, 5);
    check("limit", rsp_limit, 9'h005);
    card_link_model_inst.send_rsp(5, 8'h90, 8'h00);
    check("done", {rsp_done, status_1, status_2}, 17'h19000);
    @(negedge sys_clk);
    check("ok", error_flags, 6'h00);
    card_link_model_inst.send_rsp(6, 8'h62, 8'h81);
    check("trail", {status_1, status_2}, 16'h6281);
    @(negedge sys_clk);
    check("long", error_flags, 6'h20);
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1ms;
    num_errors++;
    test_done;
  end
  initial begin
    {resetn, cmd_start, secure_messaging, sfi_check, cmd_valid, cmd_last, cmd_case, cmd_data} = 0;
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    t_cases;
    t_header;
    t_length;
    t_resp;
    test_done;
  end
endmodule
